/* logic/clock_mode_standby_controller.sv */
// Purpose: clock source selection, prescaler, standby gating and oscillator control
// Assumes: oscillator inputs are one-cycle ticks synchronous to sys_clk, slower than
//          half the sys_clk rate; clocks leave as one-cycle enables
// Notes: AHB-Lite slave; writes zero wait, reads one wait state
//
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_cfg.svh"
module clock_mode_standby_controller
    import clk_ctrl_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int WAIT_CNT_W = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic main_osc_tick,
    input wire logic main_cr_osc_tick,
    input wire logic sub_osc_tick,
    input wire logic sub_cr_osc_tick,
    input wire logic wake_req,
    output logic main_osc_en,
    output logic main_cr_osc_en,
    output logic sub_osc_en,
    output logic sub_cr_osc_en,
    output logic machine_clk_tick,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic tbt_clk_en,
    output logic watch_presc_clk_en,
    output logic pin_hold,
    output logic deep_standby,
    output logic sw_reset_req
);
    ////////////////////////////////////////////////////////////////////////
    // registers and state
    clk_mode_e req_mode;
    clk_mode_e active_mode;
    logic [1:0] div_sel;
    logic [3:0] pll_mult;
    logic [3:0] osc_enable;
    wait_sel_t main_wait;
    wait_sel_t sub_wait;
    logic pin_hold_sel;
    logic deep_sel;
    standby_e sb_state;
    logic stop_from_main;

    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic rd_pend;
    logic [ADDR_W-1:0] rd_addr;
    logic addr_ok;
    logic wr_fire;
    logic sb_write;

    stab_if st_main();
    stab_if st_main_cr();
    stab_if st_sub();
    stab_if st_sub_cr();

    logic main_half;
    logic sub_half;
    logic sub_cr_half;
    logic [3:0] pll_left;
    logic main_src_tick;
    logic sub_src_tick;
    logic sub_cr_src_tick;
    logic pll_src_tick;
    logic sel_tick;
    logic [3:0] presc_cnt;
    logic src_ok;
    logic req_ok;
    logic next_mclk;

    function automatic logic main_family(input clk_mode_e m);
        main_family = (m == MODE_MAIN) || (m == MODE_MAIN_CR) || (m == MODE_PLL);
    endfunction : main_family

    function automatic logic [3:0] div_limit(input logic [1:0] d);
        case (d)
            2'h0: div_limit = 4'h0;
            2'h1: div_limit = 4'h3;
            2'h2: div_limit = 4'h7;
            default: div_limit = 4'hF;
        endcase
    endfunction : div_limit

    function automatic logic src_ready(input clk_mode_e m, input logic [3:0] rdy);
        case (m)
            MODE_MAIN: src_ready = rdy[`OER_MAIN];
            MODE_MAIN_CR: src_ready = rdy[`OER_MAIN_CR];
            MODE_PLL: src_ready = rdy[`OER_MAIN_CR];
            MODE_SUB: src_ready = rdy[`OER_SUB];
            default: src_ready = rdy[`OER_SUB_CR];
        endcase
    endfunction : src_ready

    logic [3:0] ready_vec;
    assign ready_vec = {st_sub_cr.ready, st_sub.ready, st_main_cr.ready, st_main.ready};

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave
    assign addr_ok = hsel && htrans[1] && hready;
    assign wr_fire = wr_pend;
    assign sb_write = wr_fire && (wr_addr == `OFS_STANDBY_ENTRY);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            rd_pend <= 1'b0;
            rd_addr <= '0;
        end else begin
            if (hready) begin
                wr_pend <= addr_ok && hwrite;
                rd_pend <= addr_ok && !hwrite;
                wr_addr <= haddr;
                rd_addr <= haddr;
            end else begin
                wr_pend <= 1'b0;
                rd_pend <= 1'b0;
            end
        end
    end

    // read inserts one wait so the data come from a flop and see the latest write
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (rd_pend) begin
                hreadyout <= 1'b1;
            end else if (addr_ok && !hwrite) begin
                hreadyout <= 1'b0;
            end
            if (rd_pend) begin
                hrdata <= 32'h00000000;
                case (rd_addr)
                    `OFS_SYS_CLK_SELECT: begin
                        hrdata[`SCS_REQ_LSB +: 3] <= req_mode;
                        hrdata[`SCS_DIV_LSB +: 2] <= div_sel;
                        hrdata[`SCS_CUR_LSB +: 3] <= active_mode;
                    end
                    `OFS_PLL_MULT: hrdata[3:0] <= pll_mult;
                    `OFS_STANDBY_ENTRY: hrdata[`SEC_PIN_HOLD] <= pin_hold_sel;
                    `OFS_OSC_ENABLE_READY: begin
                        hrdata[3:0] <= osc_enable;
                        hrdata[`OER_READY_LSB +: 4] <= ready_vec;
                    end
                    `OFS_STAB_WAIT: begin
                        hrdata[`SWS_MAIN_LSB +: 4] <= main_wait;
                        hrdata[`SWS_SUB_LSB +: 4] <= sub_wait;
                    end
                    `OFS_DEEP_STANDBY: hrdata[0] <= deep_sel;
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // undefined mode codes are ignored, old request stays
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_mode <= MODE_MAIN_CR;
            div_sel <= `RST_DIV_SEL;
        end else if (wr_fire && wr_addr == `OFS_SYS_CLK_SELECT) begin
            if (hwdata[`SCS_REQ_LSB +: 3] <= 3'(MODE_SUB_CR)) begin
                req_mode <= clk_mode_e'(hwdata[`SCS_REQ_LSB +: 3]);
            end
            div_sel <= hwdata[`SCS_DIV_LSB +: 2];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pll_mult <= `RST_PLL_MULT;
            osc_enable <= `RST_OSC_ENABLE;
            deep_sel <= 1'b0;
        end else if (wr_fire) begin
            if (wr_addr == `OFS_PLL_MULT) begin
                pll_mult <= hwdata[3:0];
            end
            if (wr_addr == `OFS_OSC_ENABLE_READY) begin
                osc_enable <= hwdata[3:0];
            end
            if (wr_addr == `OFS_DEEP_STANDBY) begin
                deep_sel <= hwdata[0];
            end
        end
    end

    // oversized selections clamp to the longest legal wait
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_wait <= `RST_MAIN_WAIT;
            sub_wait <= `RST_SUB_WAIT;
        end else if (wr_fire && wr_addr == `OFS_STAB_WAIT) begin
            main_wait <= (hwdata[`SWS_MAIN_LSB +: 4] > `MAIN_WAIT_MAX) ?
                `MAIN_WAIT_MAX : hwdata[`SWS_MAIN_LSB +: 4];
            sub_wait <= (hwdata[`SWS_SUB_LSB +: 4] > `SUB_WAIT_MAX) ?
                `SUB_WAIT_MAX : hwdata[`SWS_SUB_LSB +: 4];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // standby state
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sb_state <= SB_RUN;
            stop_from_main <= 1'b0;
        end else begin
            case (sb_state)
                SB_RUN: begin
                    if (sb_write) begin
                        if (hwdata[`SEC_STOP]) begin
                            sb_state <= SB_STOP;
                            stop_from_main <= main_family(active_mode);
                        end else if (hwdata[`SEC_TBT] && main_family(active_mode)) begin
                            sb_state <= SB_TBT;
                        end else if (hwdata[`SEC_WATCH] && !main_family(active_mode)) begin
                            sb_state <= SB_WATCH;
                        end else if (hwdata[`SEC_SLEEP]) begin
                            sb_state <= SB_SLEEP;
                        end
                    end
                end
                SB_SLEEP, SB_TBT, SB_WATCH, SB_STOP: begin
                    if (wake_req) begin
                        sb_state <= SB_RUN;
                        stop_from_main <= 1'b0;
                    end
                end
                default: sb_state <= SB_RUN;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_hold_sel <= 1'b0;
            pin_hold <= 1'b0;
            sw_reset_req <= 1'b0;
            deep_standby <= 1'b0;
        end else begin
            if (sb_write) begin
                pin_hold_sel <= hwdata[`SEC_PIN_HOLD];
            end
            pin_hold <= pin_hold_sel && (sb_state == SB_STOP || sb_state == SB_TBT ||
                sb_state == SB_WATCH);
            sw_reset_req <= sb_write && hwdata[`SEC_SW_RESET];
            deep_standby <= deep_sel && (sb_state != SB_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator control and stabilization waits
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_osc_en <= 1'b0;
            main_cr_osc_en <= 1'b1;
            sub_osc_en <= 1'b0;
            sub_cr_osc_en <= 1'b0;
        end else begin
            main_osc_en <= (active_mode == MODE_MAIN || req_mode == MODE_MAIN ||
                osc_enable[`OER_MAIN]) &&
                sb_state != SB_STOP && sb_state != SB_WATCH;
            main_cr_osc_en <= (active_mode == MODE_MAIN_CR || active_mode == MODE_PLL ||
                req_mode == MODE_MAIN_CR || req_mode == MODE_PLL ||
                osc_enable[`OER_MAIN_CR]) &&
                sb_state != SB_STOP && sb_state != SB_WATCH;
            sub_osc_en <= (active_mode == MODE_SUB || req_mode == MODE_SUB ||
                osc_enable[`OER_SUB]) &&
                (sb_state != SB_STOP || (stop_from_main && osc_enable[`OER_SUB]));
            sub_cr_osc_en <= (active_mode == MODE_SUB_CR || req_mode == MODE_SUB_CR ||
                osc_enable[`OER_SUB_CR]) &&
                (sb_state != SB_STOP || (stop_from_main && osc_enable[`OER_SUB_CR]));
        end
    end

    assign st_main.osc_en = main_osc_en;
    assign st_main.osc_tick = main_osc_tick;
    assign st_main.wait_sel = main_wait;
    assign st_sub.osc_en = sub_osc_en;
    assign st_sub.osc_tick = sub_osc_tick;
    assign st_sub.wait_sel = sub_wait;
    assign st_main_cr.osc_en = main_cr_osc_en;
    assign st_main_cr.osc_tick = main_cr_osc_tick;
    assign st_main_cr.wait_sel = `CR_WAIT_SEL;
    assign st_sub_cr.osc_en = sub_cr_osc_en;
    assign st_sub_cr.osc_tick = sub_cr_osc_tick;
    assign st_sub_cr.wait_sel = `CR_WAIT_SEL;

    stab_wait_timer #(.CNT_W(WAIT_CNT_W)) u_wait_main (.sys_clk(sys_clk), .reset_n(reset_n),
        .st(st_main.timer));
    stab_wait_timer #(.CNT_W(WAIT_CNT_W)) u_wait_main_cr (.sys_clk(sys_clk),
        .reset_n(reset_n), .st(st_main_cr.timer));
    stab_wait_timer #(.CNT_W(WAIT_CNT_W)) u_wait_sub (.sys_clk(sys_clk), .reset_n(reset_n),
        .st(st_sub.timer));
    stab_wait_timer #(.CNT_W(WAIT_CNT_W)) u_wait_sub_cr (.sys_clk(sys_clk),
        .reset_n(reset_n), .st(st_sub_cr.timer));

    ////////////////////////////////////////////////////////////////////////
    // source clocks
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_half <= 1'b0;
            sub_half <= 1'b0;
            sub_cr_half <= 1'b0;
        end else begin
            if (main_osc_tick) begin
                main_half <= ~main_half;
            end
            if (sub_osc_tick) begin
                sub_half <= ~sub_half;
            end
            if (sub_cr_osc_tick) begin
                sub_cr_half <= ~sub_cr_half;
            end
        end
    end

    assign main_src_tick = main_osc_tick && main_half && main_osc_en;
    assign sub_src_tick = sub_osc_tick && sub_half && sub_osc_en;
    assign sub_cr_src_tick = sub_cr_osc_tick && sub_cr_half && sub_cr_osc_en;

    // burst of pll_mult ticks per main CR period; limited to sys_clk rate
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pll_left <= 4'h0;
        end else if (main_cr_osc_tick && main_cr_osc_en) begin
            pll_left <= pll_mult;
        end else if (pll_left != 4'h0) begin
            pll_left <= pll_left - 4'h1;
        end
    end
    assign pll_src_tick = (pll_left != 4'h0);

    always_comb begin
        case (active_mode)
            MODE_MAIN: sel_tick = main_src_tick;
            MODE_MAIN_CR: sel_tick = main_cr_osc_tick && main_cr_osc_en;
            MODE_PLL: sel_tick = pll_src_tick;
            MODE_SUB: sel_tick = sub_src_tick;
            default: sel_tick = sub_cr_src_tick;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler and glitch-free switch
    assign next_mclk = sel_tick && (presc_cnt == 4'h0);
    assign src_ok = src_ready(active_mode, ready_vec);
    assign req_ok = src_ready(req_mode, ready_vec);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            presc_cnt <= 4'h0;
        end else if (active_mode != req_mode && req_ok && presc_cnt == 4'h0 && !sel_tick) begin
            presc_cnt <= 4'h0;
        end else if (sel_tick) begin
            presc_cnt <= (presc_cnt == 4'h0) ? div_limit(div_sel) : presc_cnt - 4'h1;
        end
    end

    // change only between machine clock periods and once the new source is stable
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            active_mode <= MODE_MAIN_CR;
        end else if (sb_state == SB_RUN && active_mode != req_mode && req_ok &&
                     presc_cnt == 4'h0 && !sel_tick) begin
            active_mode <= req_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock gating
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            machine_clk_tick <= 1'b0;
            cpu_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            tbt_clk_en <= 1'b0;
            watch_presc_clk_en <= 1'b0;
        end else begin
            machine_clk_tick <= next_mclk && src_ok;
            cpu_clk_en <= next_mclk && src_ok && sb_state == SB_RUN;
            periph_clk_en <= next_mclk && src_ok &&
                (sb_state == SB_RUN || sb_state == SB_SLEEP);
            tbt_clk_en <= next_mclk && src_ok && main_family(active_mode) &&
                (sb_state == SB_RUN || sb_state == SB_SLEEP || sb_state == SB_TBT);
            watch_presc_clk_en <= (osc_enable[`OER_SUB] || active_mode == MODE_SUB) ?
                (sub_src_tick && st_sub.ready) :
                (sub_cr_src_tick && st_sub_cr.ready);
        end
    end
endmodule : clock_mode_standby_controller
`default_nettype wire

/* logic/clk_ctrl_cfg.svh */
// Purpose: offsets, field positions, reset values and counts of the clock controller
// Assumes: 32-bit AHB-Lite register bus, one register per aligned word
// Notes: definitions only
`ifndef CLK_CTRL_CFG_SVH
`define CLK_CTRL_CFG_SVH

`define OFS_SYS_CLK_SELECT 8'h00
`define OFS_PLL_MULT 8'h04
`define OFS_STANDBY_ENTRY 8'h08
`define OFS_OSC_ENABLE_READY 8'h0C
`define OFS_STAB_WAIT 8'h10
`define OFS_DEEP_STANDBY 8'h14

// system_clock_select_reg fields
`define SCS_REQ_LSB 0
`define SCS_DIV_LSB 4
`define SCS_CUR_LSB 8
// standby_entry_control_reg fields
`define SEC_SLEEP 0
`define SEC_TBT 1
`define SEC_WATCH 2
`define SEC_STOP 3
`define SEC_PIN_HOLD 4
`define SEC_SW_RESET 5
// oscillator_enable_ready_reg fields: enables at LSB, ready flags at LSB + 8
`define OER_MAIN 0
`define OER_MAIN_CR 1
`define OER_SUB 2
`define OER_SUB_CR 3
`define OER_READY_LSB 8
// stabilization_wait_setting_reg fields
`define SWS_MAIN_LSB 0
`define SWS_SUB_LSB 4

`define RST_OSC_ENABLE 4'h2
`define RST_DIV_SEL 2'h0
`define RST_PLL_MULT 4'h2
`define RST_MAIN_WAIT 4'hD
`define RST_SUB_WAIT 4'hE
// 14 main choices (0..13), 15 sub choices (0..14)
`define MAIN_WAIT_MAX 4'hD
`define SUB_WAIT_MAX 4'hE
// internal CR oscillators settle fast; fixed short wait
`define CR_WAIT_SEL 4'h2

`endif

/* logic/clk_ctrl_pkg.sv */
// Purpose: types shared by the clock controller files
// Assumes: nothing
// Notes: mode codes are the enum order, also the register encoding
package clk_ctrl_pkg;
    typedef enum logic [2:0] {MODE_MAIN, MODE_MAIN_CR, MODE_PLL, MODE_SUB, MODE_SUB_CR} clk_mode_e;
    typedef enum logic [2:0] {SB_RUN, SB_SLEEP, SB_TBT, SB_WATCH, SB_STOP} standby_e;
    typedef logic [3:0] wait_sel_t;
endpackage : clk_ctrl_pkg

/* logic/stab_if.sv */
// Purpose: link between the controller and one stabilization wait timer
// Assumes: osc_tick is one sys_clk cycle per oscillator period
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface stab_if;
    logic osc_en;
    logic osc_tick;
    logic [3:0] wait_sel;
    logic ready;
    modport ctrl (output osc_en, output osc_tick, output wait_sel, input ready);
    modport timer (input osc_en, input osc_tick, input wait_sel, output ready);
endinterface : stab_if
`default_nettype wire

/* logic/stab_wait_timer.sv */
// Purpose: oscillation stabilization wait of one oscillator
// Assumes: wait length is 2**wait_sel oscillator ticks
// Notes: counter clears whenever the oscillator is disabled
`timescale 1ns/1ps
`default_nettype none
module stab_wait_timer #(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    stab_if.timer st
);
    logic [CNT_W-1:0] cnt;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= '0;
        end else if (!st.osc_en) begin
            cnt <= '0;
        end else if (st.osc_tick && !st.ready) begin
            cnt <= cnt + 1'b1;
        end
    end

    // ready stays set while enabled; saturates at the selected length
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st.ready <= 1'b0;
        end else if (!st.osc_en) begin
            st.ready <= 1'b0;
        end else if (cnt[st.wait_sel]) begin
            st.ready <= 1'b1;
        end
    end
endmodule : stab_wait_timer
`default_nettype wire

/* verif/clock_mode_standby_controller_sva.sv */
// Purpose: port-level checker of the clock controller
// Assumes: one sys_clk domain, asynchronous active-low reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module clock_mode_standby_controller_sva (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic machine_clk_tick,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic tbt_clk_en,
    input wire logic pin_hold,
    input wire logic deep_standby,
    input wire logic sw_reset_req
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    chk_cpu_gated: assert property (cpu_clk_en |-> machine_clk_tick && periph_clk_en)
        else $error("cpu enable without machine tick");
    chk_periph_gated: assert property (periph_clk_en |-> machine_clk_tick)
        else $error("peripheral enable without machine tick");
    chk_tbt_gated: assert property (tbt_clk_en |-> machine_clk_tick)
        else $error("time-base enable without machine tick");
    chk_cpu_run_only: assert property (cpu_clk_en |-> !deep_standby && !pin_hold)
        else $error("cpu clocked while in standby");
    chk_read_wait: assert property (hsel && htrans[1] && hready && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
    chk_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
        else $error("write stalled");
    chk_resp_okay: assert property (!hresp)
        else $error("error response");
    chk_reset_pulse: assert property (sw_reset_req |=> !sw_reset_req)
        else $error("software reset request too long");
endmodule : clock_mode_standby_controller_sva
bind clock_mode_standby_controller clock_mode_standby_controller_sva i_sva (.sys_clk(sys_clk),
    .reset_n(reset_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .machine_clk_tick(machine_clk_tick),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .tbt_clk_en(tbt_clk_en),
    .pin_hold(pin_hold), .deep_standby(deep_standby), .sw_reset_req(sw_reset_req));
`default_nettype wire

/* verif/clock_mode_standby_controller_test.sv */
// Purpose: directed bench of the clock controller
// Assumes: oscillators modelled as periodic ticks, silent while disabled
// Notes: small wait selections keep the run short
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_cfg.svh"
module clock_mode_standby_controller_test import clk_ctrl_pkg::*;;
    logic sys_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, wake_req;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata, rd, cm, cc, cp, ct, cw, cs;
    logic mo_t, mc_t, so_t, sc_t, mo_en, mc_en, so_en, sc_en, mt, cpu, per, tbt, wp, ph, ds, swr;
    int failures, total_checks, cyc;
    assign hready = hreadyout;
    clock_mode_standby_controller i_clock_mode_standby_controller (.sys_clk(sys_clk),
        .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .main_osc_tick(mo_t), .main_cr_osc_tick(mc_t), .sub_osc_tick(so_t),
        .sub_cr_osc_tick(sc_t), .wake_req(wake_req), .main_osc_en(mo_en),
        .main_cr_osc_en(mc_en), .sub_osc_en(so_en), .sub_cr_osc_en(sc_en),
        .machine_clk_tick(mt), .cpu_clk_en(cpu), .periph_clk_en(per), .tbt_clk_en(tbt),
        .watch_presc_clk_en(wp), .pin_hold(ph), .deep_standby(ds), .sw_reset_req(swr));
    initial begin
        sys_clk = 0;
        forever #25 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // a disabled oscillator gives no ticks, as the real one would
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        mo_t <= mo_en && (cyc % 4 == 0);
        mc_t <= mc_en && (cyc % 6 == 0);
        so_t <= so_en && (cyc % 8 == 0);
        sc_t <= sc_en && (cyc % 10 == 0);
        if (cyc == 10000) begin
            failures++;
            report_and_stop();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= a;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk
    // settle first so the window holds whole prescaler periods only
    task measure(input int s, input int n);
        repeat (s) @(posedge sys_clk);
        {cm, cc, cp, ct, cw, cs} = '0;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            cm += mt; cc += cpu; cp += per; ct += tbt; cw += wp; cs += swr;
        end
    endtask : measure
    task poll_mode(input logic [2:0] m);
        repeat (200) begin
            bus(0, `OFS_SYS_CLK_SELECT, 32'h0);
            if (rd[10:8] === m) break;
        end
        check({29'h0, rd[10:8]}, {29'h0, m});
    endtask : poll_mode
    task wake();
        @(posedge sys_clk); wake_req <= 1;
        @(posedge sys_clk); wake_req <= 0;
    endtask : wake
    task report_and_stop();
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset_regs();
        rdchk(`OFS_OSC_ENABLE_READY, 32'h2);
        measure(40, 120);
        check(cm, 20);
        rdchk(`OFS_OSC_ENABLE_READY, 32'h202);
        rdchk(`OFS_SYS_CLK_SELECT, 32'h101);
        rdchk(`OFS_PLL_MULT, 32'h2);
        rdchk(`OFS_STAB_WAIT, 32'hED);
        rdchk(8'h18, 32'h0);
        bus(1, `OFS_SYS_CLK_SELECT, 32'h11);
        measure(48, 240);
        check(cm, 10);
        bus(1, `OFS_SYS_CLK_SELECT, {29'h0, MODE_PLL});
        poll_mode(MODE_PLL);
        measure(48, 240);
        check(cm, 80);
    endtask : t_reset_regs
    task t_main_standby();
        bus(1, `OFS_STAB_WAIT, 32'h10);
        bus(1, `OFS_OSC_ENABLE_READY, 32'h3);
        bus(1, `OFS_SYS_CLK_SELECT, {29'h0, MODE_MAIN});
        poll_mode(MODE_MAIN);
        measure(48, 240);
        check(cm, 30);
        rdchk(`OFS_OSC_ENABLE_READY, 32'h303);
        bus(1, `OFS_DEEP_STANDBY, 32'h1);
        bus(1, `OFS_STANDBY_ENTRY, 32'h1);
        measure(48, 240);
        check(cc, 0);
        check(cp, 30);
        check({31'h0, ds}, 1);
        wake();
        bus(1, `OFS_DEEP_STANDBY, 32'h0);
        bus(1, `OFS_STANDBY_ENTRY, 32'h12);
        measure(48, 240);
        check(cp, 0);
        check(ct, 30);
        check({31'h0, ph}, 1);
        wake();
        bus(1, `OFS_STANDBY_ENTRY, 32'h4);
        measure(48, 240);
        check(cc, 30);
    endtask : t_main_standby
    task t_sub_standby();
        bus(1, `OFS_SYS_CLK_SELECT, {29'h0, MODE_SUB});
        poll_mode(MODE_SUB);
        check({31'h0, mo_en}, 1);
        bus(1, `OFS_STANDBY_ENTRY, 32'h2);
        measure(48, 240);
        check(cc, 15);
        bus(1, `OFS_STANDBY_ENTRY, 32'h4);
        measure(48, 240);
        check(cc, 0);
        check(cw, 15);
        check({31'h0, mo_en}, 0);
        check({31'h0, mc_en}, 0);
        wake();
        bus(1, `OFS_STANDBY_ENTRY, 32'h8);
        measure(48, 240);
        check(cm, 0);
        check(cw, 0);
        check({30'h0, mo_en, so_en}, 0);
        check({31'h0, sc_en}, 0);
        wake();
        bus(1, `OFS_SYS_CLK_SELECT, {29'h0, MODE_SUB_CR});
        poll_mode(MODE_SUB_CR);
        measure(48, 240);
        check(cm, 12);
        bus(1, `OFS_STANDBY_ENTRY, 32'h20);
        // the pulse stands only until the next edge: look at it now
        #1;
        check({31'h0, swr}, 1);
        measure(0, 6);
        check(cs, 0);
    endtask : t_sub_standby
    initial begin
        failures = 0; total_checks = 0; cyc = 0; reset_n = 0; wake_req = 0;
        hsel = 0; htrans = 0; hwrite = 0; haddr = 0; hwdata = 0;
        {mo_t, mc_t, so_t, sc_t} = 4'h0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1;
        t_reset_regs();
        t_main_standby();
        t_sub_standby();
        report_and_stop();
    end
endmodule : clock_mode_standby_controller_test
`default_nettype wire
